//--- vicm_cfg.svh
`ifndef VICM_CFG_SVH
`define VICM_CFG_SVH
// Functional notes
// - compare writes one when true, else zero
// - less-or-equal compares in all three forms
// - greater-than only with scalar or immediate
// - no greater-or-equal scalar compare exists
// - no less-than compare with immediate
// - signed immediate spans minus sixteen to fifteen
// - unsigned immediate, high bit clear, is 0-15
// - immediate always sign-extended, even when unsigned
// - greater-or-equal immediate uses greater-than instead
// - compares always use tail-agnostic policy
// - mask-undisturbed compare keeps inactive destination bits
// - signed and unsigned minimum and maximum
// - multiply forms double product, keeps half
// - low half, or signed high half
// - unsigned high-half multiply, both operands unsigned
// - mixed high-half: vector source two signed
// - high-half multiply never scales, rounds, overflows
// - divide and remainder match scalar integer divide

// default element width in bits
`define VICM_SEW_DEFAULT 32
// width of the short signed immediate
`define VICM_IMM_WIDTH 5
// reset value of the ready flag
`define VICM_READY_RST 1'b1
`endif

//--- vicm_pkg.sv
`include "vicm_cfg.svh"

package vicm_pkg;

  // operations executed by the unit
  typedef enum logic [4:0] {
    VICM_OP_EQ, VICM_OP_NE, VICM_OP_LTU, VICM_OP_LT,
    VICM_OP_LEU, VICM_OP_LE, VICM_OP_GTU, VICM_OP_GT,
    VICM_OP_MINU, VICM_OP_MIN, VICM_OP_MAXU, VICM_OP_MAX,
    VICM_OP_MUL, VICM_OP_MULH, VICM_OP_MULHU, VICM_OP_MULHSU,
    VICM_OP_DIVU, VICM_OP_DIV, VICM_OP_REMU, VICM_OP_REM
  } vicm_op_type;

  // source of the second operand
  typedef enum logic [1:0] {
    VICM_FORM_VV, VICM_FORM_VX, VICM_FORM_VI
  } vicm_form_type;

  // per-element control from the issue logic
  typedef struct packed {
    vicm_op_type                 op;
    vicm_form_type               form;
    logic [`VICM_IMM_WIDTH-1:0]  shortSignedImmediate;
    logic                        maskSelectBit;       // low: masked encoding
    logic                        maskRegisterZeroBit; // element bit of mask register zero
    logic                        maskUndisturbed;
    logic                        tailAgnostic;
    logic                        tailElement;         // element index at or past vector length
  } vicm_ctrl_type;

endpackage : vicm_pkg

//--- vicm_div.sv
`timescale 1ns/1ps
`default_nettype none

module vicm_div #(
  parameter int SEW = `VICM_SEW_DEFAULT
) (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // request
  input  wire logic           start,
  input  wire logic [SEW-1:0] dividend,
  input  wire logic [SEW-1:0] divisor,
  input  wire logic           signedOp,
  input  wire logic           remOp,
  // answer
  output logic                done,
  output logic [SEW-1:0]      result
);
  import vicm_pkg::*;

  localparam int CW = $clog2(SEW) + 1;

  typedef struct packed {
    logic           busy;
    logic           done;
    logic [CW-1:0]  cnt;
    logic [SEW-1:0] rem;
    logic [SEW-1:0] quo;
    logic [SEW-1:0] dsr;
    logic           negQ;
    logic           negR;
    logic           remSel;
    logic [SEW-1:0] result;
  } vicm_div_state_type;

  vicm_div_state_type s_reg;
  vicm_div_state_type s_next;

  // one restoring step per cycle on magnitudes, sign fixed at the end
  always_comb begin
    logic [SEW:0]   shifted;
    logic [SEW:0]   diff;
    logic [SEW-1:0] magA;
    logic [SEW-1:0] magB;
    shifted = '0;
    diff    = '0;
    magA    = (signedOp && dividend[SEW-1]) ? SEW'(-dividend) : dividend;
    magB    = (signedOp && divisor[SEW-1]) ? SEW'(-divisor) : divisor;
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (start && !s_reg.busy) begin
      s_next.remSel = remOp;
      if (divisor == '0) begin
        s_next.result = remOp ? dividend : '1;
        s_next.done   = 1'b1;
      end else if (signedOp && dividend == {1'b1, {(SEW-1){1'b0}}} && divisor == '1) begin
        s_next.result = remOp ? '0 : dividend;
        s_next.done   = 1'b1;
      end else begin
        s_next.busy = 1'b1;
        s_next.cnt  = CW'(SEW);
        s_next.rem  = '0;
        s_next.quo  = magA;
        s_next.dsr  = magB;
        s_next.negQ = signedOp && (dividend[SEW-1] ^ divisor[SEW-1]);
        s_next.negR = signedOp && dividend[SEW-1];
      end
    end else if (s_reg.busy) begin
      if (s_reg.cnt != '0) begin
        shifted = {s_reg.rem, s_reg.quo[SEW-1]};
        diff    = shifted - {1'b0, s_reg.dsr};
        if (!diff[SEW]) begin
          s_next.rem = diff[SEW-1:0];
          s_next.quo = {s_reg.quo[SEW-2:0], 1'b1};
        end else begin
          s_next.rem = shifted[SEW-1:0];
          s_next.quo = {s_reg.quo[SEW-2:0], 1'b0};
        end
        s_next.cnt = s_reg.cnt - 1'b1;
      end else begin
        // quotient truncates toward zero, remainder takes dividend sign
        if (s_reg.remSel) begin
          s_next.result = s_reg.negR ? SEW'(-s_reg.rem) : s_reg.rem;
        end else begin
          s_next.result = s_reg.negQ ? SEW'(-s_reg.quo) : s_reg.quo;
        end
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done   = s_reg.done;
  assign result = s_reg.result;

endmodule : vicm_div

`default_nettype wire

//--- vicm_unit.sv
`timescale 1ns/1ps
`default_nettype none

module vicm_unit #(
  parameter int SEW = `VICM_SEW_DEFAULT
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // request from issue logic
  input  wire logic               reqValid,
  input  wire vicm_pkg::vicm_ctrl_type reqCtrl,
  input  wire logic [SEW-1:0]     vectorSourceTwo,
  input  wire logic [SEW-1:0]     vectorSourceOne,
  input  wire logic [SEW-1:0]     scalarOperand,
  input  wire logic [SEW-1:0]     oldDest,
  output logic                    reqReady,
  // result to register file
  output logic                    respValid,
  output logic [SEW-1:0]          respData,
  output logic                    respWriteEn,
  output logic                    respMaskWrite,
  output logic                    respIllegal
);
  import vicm_pkg::*;

  localparam int IW = `VICM_IMM_WIDTH;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DIV
  } vicm_fsm_type;

  typedef struct packed {
    vicm_fsm_type   fsm;
    logic           ready;
    logic           respValid;
    logic [SEW-1:0] result;
    logic           writeEn;
    logic           maskWrite;
    logic           illegal;
    logic           divStart;
    logic [SEW-1:0] divA;
    logic [SEW-1:0] divB;
    logic           divSigned;
    logic           divRem;
  } vicm_unit_state_type;

  vicm_unit_state_type s_reg;
  vicm_unit_state_type s_next;

  logic           divDone;
  logic [SEW-1:0] divResult;

  // iterative divider for divide and remainder
  vicm_div #(
    .SEW (SEW)
  ) u_div (
    .clock    (clock),
    .rst      (rst),
    .start    (s_reg.divStart),
    .dividend (s_reg.divA),
    .divisor  (s_reg.divB),
    .signedOp (s_reg.divSigned),
    .remOp    (s_reg.divRem),
    .done     (divDone),
    .result   (divResult)
  );

  // operation class decode
  logic isCmp;
  logic isMinMax;
  logic isMul;
  logic isDiv;
  logic legal;

  always_comb begin
    isCmp    = reqCtrl.op inside {VICM_OP_EQ, VICM_OP_NE, VICM_OP_LTU, VICM_OP_LT,
                                  VICM_OP_LEU, VICM_OP_LE, VICM_OP_GTU, VICM_OP_GT};
    isMinMax = reqCtrl.op inside {VICM_OP_MINU, VICM_OP_MIN, VICM_OP_MAXU, VICM_OP_MAX};
    isMul    = reqCtrl.op inside {VICM_OP_MUL, VICM_OP_MULH, VICM_OP_MULHU, VICM_OP_MULHSU};
    isDiv    = reqCtrl.op inside {VICM_OP_DIVU, VICM_OP_DIV, VICM_OP_REMU, VICM_OP_REM};
  end

  // encodings that exist; greater-or-equal has no opcode at all
  always_comb begin
    case (reqCtrl.form)
      VICM_FORM_VV: begin
        legal = !(reqCtrl.op inside {VICM_OP_GTU, VICM_OP_GT});
      end
      VICM_FORM_VX: begin
        legal = 1'b1;
      end
      VICM_FORM_VI: begin
        // immediates only for compares, never for less-than
        legal = isCmp && !(reqCtrl.op inside {VICM_OP_LTU, VICM_OP_LT});
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // second operand select, immediate always sign-extended
  logic [SEW-1:0] immExt;
  logic [SEW-1:0] opB;

  always_comb begin
    immExt = {{(SEW-IW){reqCtrl.shortSignedImmediate[IW-1]}},
              reqCtrl.shortSignedImmediate};
    case (reqCtrl.form)
      VICM_FORM_VV: opB = vectorSourceOne;
      VICM_FORM_VX: opB = scalarOperand;
      VICM_FORM_VI: opB = immExt;
      default:      opB = '0;
    endcase
  end

  // compare outcome for one element
  logic cmpBit;

  always_comb begin
    case (reqCtrl.op)
      VICM_OP_EQ:  cmpBit = vectorSourceTwo == opB;
      VICM_OP_NE:  cmpBit = vectorSourceTwo != opB;
      VICM_OP_LTU: cmpBit = vectorSourceTwo < opB;
      VICM_OP_LT:  cmpBit = $signed(vectorSourceTwo) < $signed(opB);
      VICM_OP_LEU: cmpBit = vectorSourceTwo <= opB;
      VICM_OP_LE:  cmpBit = $signed(vectorSourceTwo) <= $signed(opB);
      VICM_OP_GTU: cmpBit = vectorSourceTwo > opB;
      VICM_OP_GT:  cmpBit = $signed(vectorSourceTwo) > $signed(opB);
      default:     cmpBit = 1'b0;
    endcase
  end

  // minimum and maximum
  logic [SEW-1:0] minMaxRes;

  always_comb begin
    case (reqCtrl.op)
      VICM_OP_MINU: minMaxRes = (vectorSourceTwo < opB) ? vectorSourceTwo : opB;
      VICM_OP_MIN:  minMaxRes = ($signed(vectorSourceTwo) < $signed(opB))
                                ? vectorSourceTwo : opB;
      VICM_OP_MAXU: minMaxRes = (vectorSourceTwo > opB) ? vectorSourceTwo : opB;
      VICM_OP_MAX:  minMaxRes = ($signed(vectorSourceTwo) > $signed(opB))
                                ? vectorSourceTwo : opB;
      default:      minMaxRes = '0;
    endcase
  end

  // full double-width product, one half returned
  logic [2*SEW-1:0] mulA;
  logic [2*SEW-1:0] mulB;
  logic [2*SEW-1:0] product;
  logic [SEW-1:0]   mulRes;

  always_comb begin
    // vector source two is signed for all but the unsigned variant
    if (reqCtrl.op == VICM_OP_MULHU) begin
      mulA = {{SEW{1'b0}}, vectorSourceTwo};
    end else begin
      mulA = {{SEW{vectorSourceTwo[SEW-1]}}, vectorSourceTwo};
    end
    // other operand unsigned for mixed and unsigned variants
    if (reqCtrl.op inside {VICM_OP_MULHU, VICM_OP_MULHSU}) begin
      mulB = {{SEW{1'b0}}, opB};
    end else begin
      mulB = {{SEW{opB[SEW-1]}}, opB};
    end
    product = mulA * mulB;
    // no rounding or saturation, just the chosen half
    if (reqCtrl.op == VICM_OP_MUL) begin
      mulRes = product[SEW-1:0];
    end else begin
      mulRes = product[2*SEW-1:SEW];
    end
  end

  // element activity under masking
  logic active;

  always_comb begin
    active = !reqCtrl.tailElement &&
             (reqCtrl.maskSelectBit || reqCtrl.maskRegisterZeroBit);
  end

  // sequencing, masking and tail policy
  always_comb begin
    s_next           = s_reg;
    s_next.respValid = 1'b0;
    s_next.divStart  = 1'b0;
    case (s_reg.fsm)
      ST_IDLE: begin
        if (reqValid && s_reg.ready) begin
          s_next.respValid = 1'b1;
          s_next.illegal   = 1'b0;
          s_next.maskWrite = isCmp;
          if (!legal) begin
            // nonexistent encoding: flagged, nothing written
            s_next.illegal = 1'b1;
            s_next.writeEn = 1'b0;
            s_next.result  = '0;
          end else if (reqCtrl.tailElement) begin
            if (isCmp || reqCtrl.tailAgnostic) begin
              s_next.result  = '1;
              s_next.writeEn = 1'b1;
            end else begin
              s_next.result  = oldDest;
              s_next.writeEn = 1'b0;
            end
          end else if (!active) begin
            if (reqCtrl.maskUndisturbed) begin
              s_next.result  = oldDest;
              s_next.writeEn = 1'b0;
            end else begin
              s_next.result  = '1;
              s_next.writeEn = 1'b1;
            end
          end else if (isCmp) begin
            s_next.result  = {{(SEW-1){1'b0}}, cmpBit};
            s_next.writeEn = 1'b1;
          end else if (isMinMax) begin
            s_next.result  = minMaxRes;
            s_next.writeEn = 1'b1;
          end else if (isMul) begin
            s_next.result  = mulRes;
            s_next.writeEn = 1'b1;
          end else if (isDiv) begin
            // hand the element to the divider and hold off new requests
            s_next.respValid = 1'b0;
            s_next.divStart  = 1'b1;
            s_next.divA      = vectorSourceTwo;
            s_next.divB      = opB;
            s_next.divSigned = reqCtrl.op inside {VICM_OP_DIV, VICM_OP_REM};
            s_next.divRem    = reqCtrl.op inside {VICM_OP_REMU, VICM_OP_REM};
            s_next.ready     = 1'b0;
            s_next.fsm       = ST_DIV;
          end else begin
            s_next.result  = '0;
            s_next.writeEn = 1'b0;
          end
        end
      end
      ST_DIV: begin
        if (divDone) begin
          s_next.respValid = 1'b1;
          s_next.result    = divResult;
          s_next.writeEn   = 1'b1;
          s_next.ready     = 1'b1;
          s_next.fsm       = ST_IDLE;
        end
      end
      default: begin
        s_next.fsm   = ST_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.fsm   <= ST_IDLE;
      s_reg.ready <= `VICM_READY_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign reqReady      = s_reg.ready;
  assign respValid     = s_reg.respValid;
  assign respData      = s_reg.result;
  assign respWriteEn   = s_reg.writeEn;
  assign respMaskWrite = s_reg.maskWrite;
  assign respIllegal   = s_reg.illegal;

endmodule : vicm_unit

`default_nettype wire

//--- vicm_issue_model.sv
`timescale 1ns/1ps
`default_nettype none

module vicm_issue_model #(
  parameter int SEW = 32
) (
  // clock and handshake
  input  wire logic                    clock,
  input  wire logic                    reqReady,
  // request to the unit
  output var logic                     reqValid,
  output var vicm_pkg::vicm_ctrl_type  reqCtrl,
  output var logic [SEW-1:0]           vectorSourceTwo,
  output var logic [SEW-1:0]           vectorSourceOne,
  output var logic [SEW-1:0]           scalarOperand,
  output var logic [SEW-1:0]           oldDest
);
  import vicm_pkg::*;

  // idle request lines at time zero
  initial begin
    reqValid = 1'b0;
    reqCtrl = '0;
    {vectorSourceTwo, vectorSourceOne, scalarOperand, oldDest} = '0;
  end

  // present one element after an idle gap and hold it until taken
  task automatic send(input vicm_ctrl_type c, input logic [SEW-1:0] a, v, s, o, input int gap);
    int n;
    repeat (gap) @(posedge clock);
    #1;
    reqValid = 1'b1;
    reqCtrl = c;
    {vectorSourceTwo, vectorSourceOne, scalarOperand, oldDest} = {a, v, s, o};
    n = 0;
    @(posedge clock);
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    #1;
    reqValid = 1'b0;
    // released lines show the inverse so stale data is never reused
    {vectorSourceTwo, vectorSourceOne, scalarOperand, oldDest} = ~{a, v, s, o};
  endtask : send
endmodule : vicm_issue_model

`default_nettype wire

//--- vicm_unit_props.sv
`timescale 1ns/1ps
`default_nettype none

module vicm_unit_props #(
  parameter int SEW = 32
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // request
  input  wire logic                    reqValid,
  input  wire vicm_pkg::vicm_ctrl_type reqCtrl,
  input  wire logic [SEW-1:0]          vectorSourceTwo,
  input  wire logic [SEW-1:0]          vectorSourceOne,
  input  wire logic [SEW-1:0]          scalarOperand,
  input  wire logic [SEW-1:0]          oldDest,
  input  wire logic                    reqReady,
  // answer
  input  wire logic                    respValid,
  input  wire logic [SEW-1:0]          respData,
  input  wire logic                    respWriteEn,
  input  wire logic                    respMaskWrite,
  input  wire logic                    respIllegal
);
  import vicm_pkg::*;

  logic           take;
  logic           live;
  logic           cmp;
  logic           bad;
  logic [SEW-1:0] immExt;

  // decode of the request being taken
  assign take = reqValid && reqReady;
  assign live = take && !reqCtrl.tailElement && (reqCtrl.maskSelectBit || reqCtrl.maskRegisterZeroBit);
  assign cmp = reqCtrl.op <= VICM_OP_GT;
  assign bad = (reqCtrl.form == VICM_FORM_VV && (reqCtrl.op == VICM_OP_GT || reqCtrl.op == VICM_OP_GTU))
            || (reqCtrl.form == VICM_FORM_VI && (reqCtrl.op == VICM_OP_LT || reqCtrl.op == VICM_OP_LTU || !cmp));
  assign immExt = {{(SEW-5){reqCtrl.shortSignedImmediate[4]}}, reqCtrl.shortSignedImmediate};

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_cmp_bit_only: assert property (live && cmp && !bad |=>
    respValid && respMaskWrite && respWriteEn && respData[SEW-1:1] == '0) else $error("compare answer malformed");
  a_le_signed: assert property (live && reqCtrl.op == VICM_OP_LE && reqCtrl.form == VICM_FORM_VX |=>
    respData[0] == ($signed($past(vectorSourceTwo)) <= $signed($past(scalarOperand)))) else $error("signed le wrong");
  a_gtu_imm_ext: assert property (live && reqCtrl.op == VICM_OP_GTU && reqCtrl.form == VICM_FORM_VI |=>
    respData[0] == ($past(vectorSourceTwo) > $past(immExt))) else $error("unsigned gt immediate wrong");
  a_refuse_form: assert property (take && bad |=> respValid && respIllegal && !respWriteEn)
    else $error("missing encoding not refused");
  a_tail_agnostic: assert property (take && cmp && !bad && reqCtrl.tailElement |=> respWriteEn && &respData)
    else $error("compare tail not agnostic");
  a_keep_dest: assert property (take && cmp && !bad && !reqCtrl.tailElement && !reqCtrl.maskSelectBit
    && !reqCtrl.maskRegisterZeroBit && reqCtrl.maskUndisturbed |=> respValid && !respWriteEn && respData == $past(oldDest))
    else $error("inactive compare disturbed destination");
  a_minu_pick: assert property (live && reqCtrl.op == VICM_OP_MINU && reqCtrl.form == VICM_FORM_VX |=>
    respData == ($past(vectorSourceTwo) < $past(scalarOperand) ? $past(vectorSourceTwo) : $past(scalarOperand)))
    else $error("unsigned minimum wrong");
  a_mul_low: assert property (live && reqCtrl.op == VICM_OP_MUL && reqCtrl.form == VICM_FORM_VV |=>
    respData == $past(vectorSourceTwo) * $past(vectorSourceOne)) else $error("low product wrong");
  a_div_busy: assert property (live && reqCtrl.op >= VICM_OP_DIVU && !bad |=> !reqReady)
    else $error("ready during divide");
  a_div_zero: assert property (live && reqCtrl.op == VICM_OP_DIVU && reqCtrl.form == VICM_FORM_VX
    && scalarOperand == '0 |=> !respValid ##1 !respValid ##1 (respValid && &respData))
    else $error("divide by zero answer wrong");
endmodule : vicm_unit_props

bind vicm_unit vicm_unit_props #(.SEW(SEW)) i_vicm_unit_props (
  .clock(clock), .rst(rst), .reqValid(reqValid), .reqCtrl(reqCtrl), .vectorSourceTwo(vectorSourceTwo),
  .vectorSourceOne(vectorSourceOne), .scalarOperand(scalarOperand), .oldDest(oldDest), .reqReady(reqReady),
  .respValid(respValid), .respData(respData), .respWriteEn(respWriteEn), .respMaskWrite(respMaskWrite),
  .respIllegal(respIllegal)
);

`default_nettype wire

//--- vicm_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none

module vicm_unit_bench;
  import vicm_pkg::*;
  localparam int W = 32;

  logic          clock, rst, reqValid, reqReady, respValid, respWriteEn, respMaskWrite, respIllegal;
  vicm_ctrl_type reqCtrl;
  logic [W-1:0]  vectorSourceTwo, vectorSourceOne, scalarOperand, oldDest, respData;
  int            num_errors, compares;

  vicm_unit #(.SEW(W)) i_vicm_unit (.clock(clock), .rst(rst), .reqValid(reqValid), .reqCtrl(reqCtrl),
    .vectorSourceTwo(vectorSourceTwo), .vectorSourceOne(vectorSourceOne), .scalarOperand(scalarOperand),
    .oldDest(oldDest), .reqReady(reqReady), .respValid(respValid), .respData(respData),
    .respWriteEn(respWriteEn), .respMaskWrite(respMaskWrite), .respIllegal(respIllegal));
  vicm_issue_model #(.SEW(W)) i_vicm_issue_model (.clock(clock), .reqReady(reqReady), .reqValid(reqValid),
    .reqCtrl(reqCtrl), .vectorSourceTwo(vectorSourceTwo), .vectorSourceOne(vectorSourceOne),
    .scalarOperand(scalarOperand), .oldDest(oldDest));

  // free running clock
  always #12.5 clock = ~clock;

  // reference result as {illegal, writeEn, data}
  function automatic logic [W+1:0] model(vicm_ctrl_type c, logic [W-1:0] a, v, s, o);
    logic [W-1:0] b, r;
    longint       x, y;
    logic         cm, mn;
    b = c.form == VICM_FORM_VV ? v : c.form == VICM_FORM_VX ? s : W'($signed(c.shortSignedImmediate));
    x = $signed(a);
    y = $signed(b);
    cm = c.op <= VICM_OP_GT;
    mn = a == 32'h80000000 && &b;
    if ((c.form == VICM_FORM_VV && (c.op == VICM_OP_GT || c.op == VICM_OP_GTU))
        || (c.form == VICM_FORM_VI && (c.op == VICM_OP_LT || c.op == VICM_OP_LTU || !cm))) return {2'b10, W'(0)};
    if (c.tailElement) return (cm || c.tailAgnostic) ? {2'b01, {W{1'b1}}} : {2'b00, o};
    if (!c.maskSelectBit && !c.maskRegisterZeroBit) return c.maskUndisturbed ? {2'b00, o} : {2'b01, {W{1'b1}}};
    case (c.op)
      VICM_OP_EQ:     r = W'(a == b);
      VICM_OP_NE:     r = W'(a != b);
      VICM_OP_LTU:    r = W'(a < b);
      VICM_OP_LT:     r = W'(x < y);
      VICM_OP_LEU:    r = W'(a <= b);
      VICM_OP_LE:     r = W'(x <= y);
      VICM_OP_GTU:    r = W'(a > b);
      VICM_OP_GT:     r = W'(x > y);
      VICM_OP_MINU:   r = a < b ? a : b;
      VICM_OP_MIN:    r = x < y ? a : b;
      VICM_OP_MAXU:   r = a > b ? a : b;
      VICM_OP_MAX:    r = x > y ? a : b;
      VICM_OP_MUL:    r = a * b;
      VICM_OP_MULH:   r = W'((x * y) >>> W);
      VICM_OP_MULHU:  r = W'((64'(a) * 64'(b)) >> W);
      VICM_OP_MULHSU: r = W'((x * 64'(b)) >> W);
      VICM_OP_DIVU:   r = b == 0 ? '1 : a / b;
      VICM_OP_REMU:   r = b == 0 ? a : a % b;
      VICM_OP_DIV:    r = b == 0 ? '1 : mn ? a : W'(x / y);
      default:        r = b == 0 ? a : mn ? '0 : W'(x % y);
    endcase
    return {2'b01, r};
  endfunction : model

  // counted comparison
  task automatic chk(string n, logic [W-1:0] e, g);
    compares++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // operand mix leaning on boundary values
  function automatic logic [W-1:0] pick();
    case ($urandom % 6)
      0: return 32'h0;
      1: return 32'h1;
      2: return 32'hffffffff;
      3: return 32'h80000000;
      4: return 32'h7fffffff;
      default: return $urandom;
    endcase
  endfunction : pick

  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    complete_run();
  end

  // every op in every form with random masking, tail and operands
  initial begin
    vicm_ctrl_type c;
    logic [W+1:0]  e;
    logic [W-1:0]  a, v, s, o;
    int            n;
    clock = 1'b0;
    rst = 1'b1;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h37189a5d));
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("reqReady", W'(1), W'(reqReady));
    chk("respValid", W'(0), W'(respValid));
    for (int k = 0; k < 480; k++) begin
      c = $bits(c)'($urandom);
      c.op = vicm_op_type'(5'(k % 20));
      c.form = vicm_form_type'(2'(k / 20 % 3));
      c.maskSelectBit |= 1'($urandom);
      c.tailElement &= 1'($urandom);
      {a, v, s, o} = {pick(), pick(), pick(), pick()};
      e = model(c, a, v, s, o);
      i_vicm_issue_model.send(c, a, v, s, o, k % 3);
      n = 0;
      while (respValid !== 1'b1 && n < 60) begin
        @(posedge clock);
        #1;
        n++;
      end
      chk("respValid", W'(1), W'(respValid));
      chk("respData", e[W-1:0], respData);
      chk("respWriteEn", W'(e[W]), W'(respWriteEn));
      chk("respIllegal", W'(e[W+1]), W'(respIllegal));
    end
    complete_run();
  end
endmodule : vicm_unit_bench

`default_nettype wire
